/* logic/interrupt_pin_two_cfg_map.svh */
// Purpose: offsets, field positions, reset values of the pin-two map / filter block
// Assumes: register index times four gives the APB byte address
// Notes:   definitions only
`ifndef INTERRUPT_PIN_TWO_CFG_MAP_SVH
`define INTERRUPT_PIN_TWO_CFG_MAP_SVH

// ==========================================================
// register indices
`define IDX_ROUTE      8'h2B
`define IDX_FILTER     8'h2C
`define IDX_POWER      8'h2D
`define IDX_SOFT_RST   8'h1F
`define IDX_EVT_STAT   8'h40
`define IDX_EVT_EN     8'h41
`define IDX_EVT_CLR    8'h42

// ==========================================================
// reset values and keys
`define ROUTE_RESET    8'h00
`define FILTER_RESET   8'h23
`define POWER_RESET    2'h0
`define SOFT_RST_KEY   8'h52

// ==========================================================
// field positions
`define RT_ACTIVE_LOW  7
`define FC_RANGE_HI    7
`define FC_RANGE_LO    6
`define FC_HS          5
`define FC_EXT         3
`define FC_RATE_HI     2
`define FC_RATE_LO     0

// ==========================================================
// event status bits
`define EV_PIN_ASSERT  0
`define EV_TRIGGER     1
`define EV_HS_CODE     2
`define EV_REFUSED     3
`define EV_WIDTH       4

`endif

/* logic/interrupt_pin_two_cfg_pkg.sv */
// Purpose: types of the pin-two map / filter block
// Assumes: codes follow the register field layout
// Notes:   constants live in interrupt_pin_two_cfg_map.svh
package interrupt_pin_two_cfg_pkg;

    // ==========================================================
    // field encodings
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_RSVD_A  = 2'h1,
        MODE_OPERATING_MODE_FIELD = 2'h2,
        MODE_RSVD_B  = 2'h3
    } op_mode_t;

    typedef enum logic [1:0] {
        RANGE_2G   = 2'h0,
        RANGE_4G   = 2'h1,
        RANGE_8G   = 2'h2,
        RANGE_RSVD = 2'h3
    } range_t;

    typedef enum logic [2:0] {
        RATE_12HZ5 = 3'h0,
        RATE_25HZ  = 3'h1,
        RATE_50HZ  = 3'h2,
        RATE_100HZ = 3'h3,
        RATE_200HZ = 3'h4,
        RATE_400HZ = 3'h5,
        RATE_RSV6  = 3'h6,
        RATE_RSV7  = 3'h7
    } rate_t;

endpackage : interrupt_pin_two_cfg_pkg

/* logic/interrupt_pin_two_map_and_filter_config.sv */
// Purpose: pin-two event routing and range / rate / bus-mode configuration over APB
// Assumes: event flags come from logic on pclk; the pin input is asynchronous
// Notes:   APB answers one cycle after the access phase starts
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "interrupt_pin_two_cfg_map.svh"

module interrupt_pin_two_map_and_filter_config
    import interrupt_pin_two_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        awake_state,
    input  wire logic        inactivity_flag,
    input  wire logic        activity_flag,
    input  wire logic        overrun_flag,
    input  wire logic        buffer_watermark_flag,
    input  wire logic        buffer_ready_flag,
    input  wire logic        sample_ready_flag,
    input  wire logic        hs_master_code_seen,
    input  wire logic        interrupt_pin_two_in,
    output logic             interrupt_pin_two_out,
    output logic             interrupt_pin_two_oe,
    output logic             conversion_trigger,
    output range_t           range_select,
    output logic             high_speed_bus_mode,
    output logic             external_trigger_enable,
    output rate_t            output_rate_select,
    output op_mode_t         operating_mode_field,
    output logic             irq
);

    // ==========================================================
    // decode helpers
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    logic [7:0]           route;
    logic [`EV_WIDTH-1:0] evt_status;
    logic [`EV_WIDTH-1:0] evt_enable;
    logic                 route_level_q;
    logic                 pin_sync1;
    logic                 pin_sync2;
    logic                 pin_sync3;

    // ==========================================================
    // APB decode
    wire       access_first = psel & penable & ~pready;
    wire       commit       = psel & penable & pready;
    wire       wr           = commit & pwrite;
    wire [7:0] wbyte        = pwdata[7:0];

    wire sel_route  = hit(paddr, `IDX_ROUTE);
    wire sel_filter = hit(paddr, `IDX_FILTER);
    wire sel_power  = hit(paddr, `IDX_POWER);
    wire sel_srst   = hit(paddr, `IDX_SOFT_RST);
    wire sel_stat   = hit(paddr, `IDX_EVT_STAT);
    wire sel_en     = hit(paddr, `IDX_EVT_EN);
    wire sel_clr    = hit(paddr, `IDX_EVT_CLR);
    wire mapped     = sel_route | sel_filter | sel_power | sel_srst | sel_stat
                    | sel_en | sel_clr;

    wire wr_route  = wr & sel_route;
    wire wr_filter = wr & sel_filter;
    wire wr_power  = wr & sel_power;
    wire soft_rst  = wr & sel_srst & (wbyte == `SOFT_RST_KEY);
    wire wr_en     = wr & sel_en;
    wire wr_clr    = wr & sel_clr;

    // ==========================================================
    // filter control field checks
    wire [1:0] w_range = wbyte[`FC_RANGE_HI:`FC_RANGE_LO];
    wire [2:0] w_rate  = wbyte[`FC_RATE_HI:`FC_RATE_LO];
    wire       w_hs    = wbyte[`FC_HS];
    wire       range_ok = (w_range != RANGE_RSVD);
    wire       rate_ok  = (w_rate != RATE_RSV6) && (w_rate != RATE_RSV7);
    // high speed may only drop, and only in standby
    wire       hs_clear_ok = ~w_hs & (operating_mode_field == MODE_STANDBY);
    wire       hs_refused  = high_speed_bus_mode ? (~w_hs & ~hs_clear_ok)
                                                 : w_hs;
    wire [1:0] w_mode   = wbyte[1:0];
    wire       mode_ok  = (w_mode == MODE_STANDBY) || (w_mode == MODE_OPERATING_MODE_FIELD);
    wire       refused  = (wr_filter & (~range_ok | ~rate_ok | hs_refused))
                        | (wr_power & ~mode_ok);

    // ==========================================================
    // read mux; reserved bits read zero
    wire [7:0] filter_rd = {range_select, high_speed_bus_mode, 1'b0,
                            external_trigger_enable, output_rate_select};
    wire [7:0] read_byte = sel_route  ? route :
                           sel_filter ? filter_rd :
                           sel_power  ? {6'h00, operating_mode_field} :
                           sel_stat   ? {4'h0, evt_status} :
                           sel_en     ? {4'h0, evt_enable} : 8'h00;

    // writes answer zero data; only reads put a register on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access_first;
            pslverr <= access_first & ~mapped;
            prdata  <= (access_first & ~pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // routing register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route <= `ROUTE_RESET;
        end else if (soft_rst) begin
            route <= `ROUTE_RESET;
        end else if (wr_route) begin
            route <= wbyte;
        end
    end

    // ==========================================================
    // filter control and operating mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_select            <= range_t'(2'(`FILTER_RESET >> `FC_RANGE_LO));
            high_speed_bus_mode     <= 1'(`FILTER_RESET >> `FC_HS);
            external_trigger_enable <= 1'b0;
            output_rate_select      <= rate_t'(3'(`FILTER_RESET));
        end else if (soft_rst) begin
            range_select            <= range_t'(2'(`FILTER_RESET >> `FC_RANGE_LO));
            high_speed_bus_mode     <= 1'(`FILTER_RESET >> `FC_HS);
            external_trigger_enable <= 1'b0;
            output_rate_select      <= rate_t'(3'(`FILTER_RESET));
        end else if (wr_filter) begin
            if (range_ok) begin
                range_select <= range_t'(w_range);
            end
            if (high_speed_bus_mode && hs_clear_ok) begin
                high_speed_bus_mode <= 1'b0;
            end
            external_trigger_enable <= wbyte[`FC_EXT];
            if (rate_ok) begin
                output_rate_select <= rate_t'(w_rate);
            end
        end
    end
    // the serial front end's master code is only logged, never obeyed

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operating_mode_field <= MODE_STANDBY;
        end else if (soft_rst) begin
            operating_mode_field <= MODE_STANDBY;
        end else if (wr_power && mode_ok) begin
            operating_mode_field <= op_mode_t'(w_mode);
        end
    end

    // ==========================================================
    // pin-two routing and drive
    wire [6:0] flags = {awake_state, inactivity_flag, activity_flag, overrun_flag,
                        buffer_watermark_flag, buffer_ready_flag, sample_ready_flag};
    // bits 5, 3, 1 follow their register, pin two, not the pin-one wording
    wire route_level = |(route[6:0] & flags);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_pin_two_out <= 1'b0;
            interrupt_pin_two_oe  <= 1'b1;
            route_level_q         <= 1'b0;
        end else begin
            interrupt_pin_two_out <= route_level ^ route[`RT_ACTIVE_LOW];
            interrupt_pin_two_oe  <= ~external_trigger_enable;
            route_level_q         <= route_level;
        end
    end

    // ==========================================================
    // external trigger input, two-flop synchroniser then edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1          <= 1'b0;
            pin_sync2          <= 1'b0;
            pin_sync3          <= 1'b0;
            conversion_trigger <= 1'b0;
        end else begin
            pin_sync1          <= interrupt_pin_two_in;
            pin_sync2          <= pin_sync1;
            pin_sync3          <= pin_sync2;
            conversion_trigger <= external_trigger_enable & pin_sync2 & ~pin_sync3;
        end
    end

    // ==========================================================
    // sticky events; a set in the clear cycle wins
    wire [`EV_WIDTH-1:0] ev_set = {refused,
                                   hs_master_code_seen,
                                   conversion_trigger,
                                   route_level & ~route_level_q};
    wire [`EV_WIDTH-1:0] ev_clr = wr_clr ? wbyte[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= {`EV_WIDTH{1'b0}};
            evt_enable <= {`EV_WIDTH{1'b0}};
            irq        <= 1'b0;
        end else begin
            evt_status <= (evt_status & ~ev_clr) | ev_set;
            if (wr_en) begin
                evt_enable <= wbyte[`EV_WIDTH-1:0];
            end
            irq <= |(evt_status & evt_enable);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ROUTE_SOFT_RESET: assert property (soft_rst |=> route == 8'h00)
        else $error("routing not cleared by soft reset");
    AST_POLARITY: assert property (
        (route_level && route[7]) |=> !interrupt_pin_two_out)
        else $error("active low pin not driven low");
    AST_AWAKE: assert property (
        (awake_state && route[6] && !route[7]) |=> interrupt_pin_two_out)
        else $error("awake not on pin two");
    AST_INACT: assert property (
        (inactivity_flag && route[5] && !route[7]) |=> interrupt_pin_two_out)
        else $error("inactivity not routed");
    AST_ACT: assert property (
        (activity_flag && route[4] && !route[7]) |=> interrupt_pin_two_out)
        else $error("activity not routed");
    AST_OVERRUN: assert property (
        (overrun_flag && route[3] && !route[7]) |=> interrupt_pin_two_out)
        else $error("overrun not routed");
    AST_WATERMARK: assert property (
        (buffer_watermark_flag && route[2] && !route[7]) |=> interrupt_pin_two_out)
        else $error("watermark not routed");
    AST_BUF_READY: assert property (
        (buffer_ready_flag && route[1] && !route[7]) |=> interrupt_pin_two_out)
        else $error("buffer ready not routed");
    AST_SAMPLE_READY: assert property (
        (sample_ready_flag && route[0] && !route[7]) |=> interrupt_pin_two_out)
        else $error("sample ready not routed");
    AST_UNROUTED_QUIET: assert property (
        (route[6:0] == 7'h00 && !route[7]) |=> !interrupt_pin_two_out)
        else $error("pin two asserted with nothing routed");
    AST_FILTER_RESET: assert property (soft_rst |=> (filter_rd == 8'h23))
        else $error("filter control not back at reset value");
    AST_RANGE_RSVD: assert property (
        (wr_filter && w_range == 2'h3) |=> $stable(range_select))
        else $error("reserved range accepted");
    AST_HS_STICKY: assert property (
        (!high_speed_bus_mode && !soft_rst) |=> !high_speed_bus_mode)
        else $error("high speed came back without reset");
    AST_HS_CODE: assert property (
        hs_master_code_seen |=> $stable(high_speed_bus_mode) || $past(soft_rst))
        else $error("master code changed bus mode");
    AST_EXT_PIN_INPUT: assert property (
        external_trigger_enable |=> !interrupt_pin_two_oe)
        else $error("pin two driven while used as trigger input");
    AST_TRIGGER: assert property (
        (external_trigger_enable && $rose(pin_sync2)) |=> conversion_trigger)
        else $error("trigger edge lost");
    AST_RATE_RSVD: assert property (
        (wr_filter && w_rate[2:1] == 2'h3) |=> $stable(output_rate_select))
        else $error("reserved rate accepted");
    AST_HS_MODE_GATE: assert property (
        (wr_filter && !w_hs && operating_mode_field != MODE_STANDBY)
        |=> $stable(high_speed_bus_mode))
        else $error("bus mode changed outside standby");
    AST_RSVD_BIT: assert property (
        (commit && !pwrite && sel_filter) |-> prdata[4] == 1'b0)
        else $error("reserved filter bit reads one");
    AST_RATE_LEGAL: assert property (output_rate_select[2:1] != 2'h3)
        else $error("output rate holds reserved code");

    // ==========================================================
    // register updates, bus answer and events
    AST_ROUTE_TAKEN: assert property (
        wr_route |=> route == $past(wbyte))
        else $error("routing write not stored");
    AST_RANGE_TAKEN: assert property (
        (wr_filter && w_range != 2'h3) |=> range_select == $past(w_range))
        else $error("legal range not stored");
    AST_RANGE_LEGAL: assert property (
        range_select != RANGE_RSVD)
        else $error("range holds reserved code");
    AST_RATE_TAKEN: assert property (
        (wr_filter && w_rate[2:1] != 2'h3) |=> output_rate_select == $past(w_rate))
        else $error("legal rate not stored");
    AST_EXT_TAKEN: assert property (
        wr_filter |=> external_trigger_enable == $past(wbyte[`FC_EXT]))
        else $error("trigger enable not stored");
    AST_HS_CLEAR: assert property (
        (wr_filter && !w_hs && operating_mode_field == MODE_STANDBY) |=> !high_speed_bus_mode)
        else $error("high speed not cleared in standby");
    AST_HS_SOFT_RESET: assert property (
        soft_rst |=> high_speed_bus_mode)
        else $error("soft reset did not restore high speed");
    AST_HS_CODE_EVENT: assert property (
        hs_master_code_seen |=> evt_status[`EV_HS_CODE])
        else $error("master code not logged");
    AST_MODE_TAKEN: assert property (
        (wr_power && !wbyte[0]) |=> operating_mode_field == $past(w_mode))
        else $error("legal mode not stored");
    AST_MODE_RSVD: assert property (
        (wr_power && wbyte[0]) |=> $stable(operating_mode_field))
        else $error("reserved mode accepted");
    AST_MODE_SOFT_RESET: assert property (
        soft_rst |=> operating_mode_field == MODE_STANDBY)
        else $error("soft reset left mode set");
    AST_REFUSED_EVENT: assert property (
        refused |=> evt_status[`EV_REFUSED])
        else $error("refused write not logged");
    AST_TRIGGER_OFF: assert property (
        !external_trigger_enable |=> !conversion_trigger)
        else $error("trigger while disabled");
    AST_OE_DRIVE: assert property (
        !external_trigger_enable |=> interrupt_pin_two_oe)
        else $error("pin two not driven as output");
    AST_PIN_LOW_IDLE: assert property (
        (!route_level && route[7]) |=> interrupt_pin_two_out)
        else $error("active low pin not idle high");
    AST_READY_PULSE: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_UNMAPPED_ERR: assert property (
        (access_first && !mapped) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not flagged");
    AST_IRQ_LEVEL: assert property (
        (|(evt_status & evt_enable)) |=> irq)
        else $error("enabled event without irq");
    AST_PIN_EVENT: assert property (
        (route_level && !route_level_q) |=> evt_status[`EV_PIN_ASSERT])
        else $error("pin assert not logged");
    AST_EVT_CLEAR: assert property (
        (wr_clr && wbyte[0] && !ev_set[0]) |=> !evt_status[0])
        else $error("event bit not cleared");

    COV_HS_CLEARED: cover property (wr_filter && hs_clear_ok ##1 !high_speed_bus_mode);
    COV_ACTIVE_LOW: cover property (route[7] && route_level ##1 !interrupt_pin_two_out);
    COV_TRIGGER:    cover property (conversion_trigger);
    COV_IRQ:        cover property (irq ##[1:20] wr_clr);
    COV_REFUSED:    cover property (refused ##1 evt_status[`EV_REFUSED]);

endmodule : interrupt_pin_two_map_and_filter_config

/* dv/host_model.sv */
// Purpose: APB master standing in for the host processor
// Assumes: one request per go pulse, bench waits for done
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps

module host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic             done
);
    // ==========================================================
    // setup, access until pready, then release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 12'h000;
            pwdata  <= 32'h0000_0000;
            done    <= 1'b0;
        end else if (psel && penable && pready) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
            done    <= 1'b1;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (go) begin
            psel    <= 1'b1;
            pwrite  <= wr;
            paddr   <= addr;
            pwdata  <= wdata;
            done    <= 1'b0;
        end else begin
            done    <= 1'b0;
        end
    end
endmodule : host_model

/* dv/interrupt_pin_two_map_and_filter_config_bench.sv */
// Purpose: self-checking bench of the pin-two map / filter block
// Assumes: one wait state per APB transfer, byte address = index*4
// Notes:   bus results checked by a queue watcher, levels checked inline
`timescale 1ns/1ps

module interrupt_pin_two_map_and_filter_config_bench;
    import interrupt_pin_two_cfg_pkg::*;
    typedef struct { logic [31:0] d; logic e; } note_t;
    logic pclk = 1'b0, presetn = 1'b0, go = 1'b0, wr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [6:0] flags = 7'h00;
    logic hs_code = 1'b0, pin_drv = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, done, out, oe, trig, irq, hs, ext;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    range_t rng;
    rate_t rate;
    op_mode_t mode;
    note_t notes[$];
    int n_fail = 0, checked = 0;
    logic [15:0] seed = 16'h004D;
    // the pin wire: design drives while oe, else the outside source
    wire pin_wire = oe ? out : pin_drv;

    always #10 pclk = ~pclk;

    host_model host_model_i (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .done(done));

    interrupt_pin_two_map_and_filter_config interrupt_pin_two_map_and_filter_config_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .awake_state(flags[6]),
        .inactivity_flag(flags[5]), .activity_flag(flags[4]), .overrun_flag(flags[3]),
        .buffer_watermark_flag(flags[2]), .buffer_ready_flag(flags[1]),
        .sample_ready_flag(flags[0]), .hs_master_code_seen(hs_code),
        .interrupt_pin_two_in(pin_wire), .interrupt_pin_two_out(out),
        .interrupt_pin_two_oe(oe), .conversion_trigger(trig), .range_select(rng),
        .high_speed_bus_mode(hs), .external_trigger_enable(ext), .output_rate_select(rate),
        .operating_mode_field(mode), .irq(irq));

    // ==========================================================
    // helpers
    function automatic logic [23:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return {seed, seed[7:0]};
    endfunction : rnd

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // upper data lanes carry random junk the block must ignore
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [31:0] exp, input logic e);
        int k;
        k = 0;
        notes.push_back('{exp, e});
        wr    <= w;
        addr  <= a;
        wdata <= {rnd(), d};
        go    <= 1'b1;
        @(posedge pclk);
        go    <= 1'b0;
        do @(posedge pclk); while (done !== 1'b1 && ++k < 20);
        if (k >= 20) begin
            check("apb_timeout", 1'b0, 1'b1);
            final_report();
        end
    endtask : apb

    // ==========================================================
    // watcher: each answer pops the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected_answer", 1'b1, 1'b0);
            end else begin
                check("prdata", prdata, notes[0].d);
                check("pslverr", pslverr, notes[0].e);
                void'(notes.pop_front());
            end
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        int b;
        int k;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h0AC, 8'h00, 32'h00, 0);
        apb(0, 12'h0B0, 8'h00, 32'h23, 0);
        check("pin_reset", out, 1'b0);
        $display("test reset done");
        for (b = 0; b < 7; b++) begin
            apb(1, 12'h0AC, 8'h01 << b, 32'h0, 0);
            flags <= 7'h7F ^ (7'h01 << b);
            step(2);
            check("pin_other_flags", out, 1'b0);
            flags <= 7'h01 << b;
            step(2);
            check("pin_routed_flag", out, 1'b1);
            flags <= 7'h00;
        end
        apb(1, 12'h0AC, 8'h81, 32'h0, 0);
        step(2);
        check("pin_low_idle", out, 1'b1);
        flags <= 7'h01;
        step(2);
        check("pin_low_active", out, 1'b0);
        flags <= 7'h00;
        $display("test routing done");
        for (b = 0; b < 4; b++) begin
            apb(1, 12'h0B0, {b[1:0], 6'h23}, 32'h0, 0);
            check("range", rng, (b < 3) ? b : 2);
        end
        for (b = 0; b < 8; b++) begin
            apb(1, 12'h0B0, {5'h16, b[2:0]}, 32'h0, 0);
            check("rate", rate, (b < 6) ? b : 5);
        end
        apb(0, 12'h0B0, 8'h00, 32'hA5, 0);
        $display("test range and rate done");
        apb(1, 12'h0B4, 8'h02, 32'h0, 0);
        apb(1, 12'h0B4, 8'h01, 32'h0, 0);
        check("mode", mode, MODE_OPERATING_MODE_FIELD);
        apb(1, 12'h0B0, 8'h85, 32'h0, 0);
        check("hs_operating_mode_field", hs, 1'b1);
        apb(1, 12'h0B4, 8'h00, 32'h0, 0);
        apb(1, 12'h0B0, 8'h85, 32'h0, 0);
        check("hs_standby", hs, 1'b0);
        apb(1, 12'h0B0, 8'hA5, 32'h0, 0);
        check("hs_set_write", hs, 1'b0);
        hs_code <= 1'b1;
        @(posedge pclk);
        hs_code <= 1'b0;
        step(2);
        check("hs_master_code", hs, 1'b0);
        apb(0, 12'h100, 8'h00, 32'h0D, 0);
        apb(1, 12'h07C, 8'h52, 32'h0, 0);
        check("hs_soft_reset", hs, 1'b1);
        apb(0, 12'h0B0, 8'h00, 32'h23, 0);
        $display("test bus mode done");
        apb(1, 12'h108, 8'h0F, 32'h0, 0);
        apb(1, 12'h104, 8'h01, 32'h0, 0);
        apb(1, 12'h0AC, 8'h01, 32'h0, 0);
        flags <= 7'h01;
        step(3);
        check("irq_raised", irq, 1'b1);
        apb(0, 12'h100, 8'h00, 32'h01, 0);
        apb(1, 12'h104, 8'h00, 32'h0, 0);
        step(2);
        check("irq_masked", irq, 1'b0);
        apb(1, 12'h104, 8'h01, 32'h0, 0);
        step(2);
        check("irq_unmasked", irq, 1'b1);
        apb(1, 12'h108, 8'h01, 32'h0, 0);
        step(2);
        check("irq_cleared", irq, 1'b0);
        apb(0, 12'h100, 8'h00, 32'h00, 0);
        flags <= 7'h00;
        $display("test interrupt done");
        apb(1, 12'h0B0, 8'h2B, 32'h0, 0);
        step(1);
        check("oe_trigger_mode", {ext, oe}, 2'b10);
        pin_drv <= 1'b1;
        for (k = 0; k < 8 && trig !== 1'b1; k++) @(posedge pclk);
        check("trigger_pulse", k < 8, 1'b1);
        apb(0, 12'h100, 8'h00, 32'h02, 0);
        pin_drv <= 1'b0;
        apb(1, 12'h0B0, 8'h23, 32'h0, 0);
        step(1);
        check("oe_restored", oe, 1'b1);
        apb(0, 12'h200, 8'h00, 32'h0, 1);
        step(2);
        $display("test trigger and unmapped done");
        final_report();
    end
endmodule : interrupt_pin_two_map_and_filter_config_bench
